// ===== dsp_decode_pkg.sv
package dsp_decode_pkg;

  // ----------------------------------------
  // Opcode values
  // ----------------------------------------
  localparam logic [7:0]  OP_BRANCH_ACC_ZERO = 8'hF6;
  localparam logic [7:0]  OP_BLOCK_PROG_DATA = 8'hFC;
  localparam logic [7:0]  OP_BLOCK_DATA_DATA = 8'hFD;
  localparam logic [7:0]  OP_DATA_MOVE       = 8'h56;
  localparam logic [7:0]  OP_LOAD_STATUS0    = 8'h50;
  localparam logic [7:0]  OP_LOAD_STATUS1    = 8'h51;
  localparam logic [7:0]  OP_STORE_STATUS0   = 8'h78;
  localparam logic [7:0]  OP_STORE_STATUS1   = 8'h79;
  localparam logic [7:0]  OP_POP_TO_MEMORY   = 8'h7A;
  localparam logic [7:0]  OP_PUSH_FROM_MEM   = 8'h54;
  localparam logic [7:0]  OP_REPEAT_IMM      = 8'hCB;
  localparam logic [7:0]  OP_REPEAT_MEM      = 8'h4B;
  localparam logic [7:0]  OP_TEST_BIT_BY_T   = 8'h57;
  localparam logic [3:0]  NIB_PORT_INPUT     = 4'h8;
  localparam logic [3:0]  NIB_TEST_BIT       = 4'h9;
  localparam logic [15:0] OP_POP_ACC_LOW     = 16'hCE1D;
  localparam logic [15:0] OP_PUSH_ACC_LOW    = 16'hCE1C;
  localparam logic [15:0] OP_BLOCK_TO_DATA   = 16'hCE04;
  localparam logic [15:0] OP_BLOCK_TO_PROG   = 16'hCE05;
  localparam logic [15:0] OP_CLEAR_TX_FRAME  = 16'hCE20;
  localparam logic [15:0] OP_INT_DISABLE     = 16'hCE01;
  localparam logic [15:0] OP_INT_ENABLE      = 16'hCE00;
  localparam logic [15:0] WORD_RESET         = 16'h0000;
  localparam logic [1:0]  WORDS_ONE          = 2'h1;
  localparam logic [1:0]  WORDS_TWO          = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [4:0] {
    CLS_NOP              = 5'h00,
    CLS_BRANCH_ACC_ZERO  = 5'h01,
    CLS_BLOCK_PROG_DATA  = 5'h02,
    CLS_BLOCK_DATA_DATA  = 5'h03,
    CLS_DATA_MOVE        = 5'h04,
    CLS_PORT_INPUT       = 5'h05,
    CLS_LOAD_STATUS0     = 5'h06,
    CLS_LOAD_STATUS1     = 5'h07,
    CLS_STORE_STATUS0    = 5'h08,
    CLS_STORE_STATUS1    = 5'h09,
    CLS_POP_TO_MEMORY    = 5'h0A,
    CLS_PUSH_FROM_MEMORY = 5'h0B,
    CLS_POP_ACC_LOW      = 5'h0C,
    CLS_PUSH_ACC_LOW     = 5'h0D,
    CLS_REPEAT_IMMEDIATE = 5'h0E,
    CLS_REPEAT_MEMORY    = 5'h0F,
    CLS_TEST_BIT_BY_T    = 5'h10,
    CLS_TEST_BIT         = 5'h11,
    CLS_BLOCK_TO_DATA    = 5'h12,
    CLS_BLOCK_TO_PROGRAM = 5'h13,
    CLS_CLEAR_TX_FRAME   = 5'h14,
    CLS_INT_DISABLE      = 5'h15,
    CLS_INT_ENABLE       = 5'h16
  } instr_class_t;

  typedef enum logic [1:0] {
    ST_OPCODE  = 2'b00,
    ST_OPERAND = 2'b01
  } fetch_state_t;

  typedef struct packed {
    instr_class_t cls;
    logic         illegal;
    logic [1:0]   words;
    logic         indirect;
    logic [6:0]   dma;
    logic [3:0]   field4;
    logic [7:0]   imm8;
  } decode_t;

  typedef struct packed {
    logic    valid;
    decode_t dec;
    logic [15:0] second_word;
  } issue_t;

endpackage

// ===== dsp_opcode_classifier.sv
module dsp_opcode_classifier
  import dsp_decode_pkg::*;
(
  input  wire logic [15:0] word,
  output decode_t          dec
);

  // ----------------------------------------
  // Match terms
  // ----------------------------------------
  wire [7:0] hi  = word[15:8];
  wire [3:0] nib = word[15:12];

  wire m_bz    = (hi == OP_BRANCH_ACC_ZERO) && word[7];
  wire m_block_move_prog_to_data  = (hi == OP_BLOCK_PROG_DATA);
  wire m_block_move_data_to_data  = (hi == OP_BLOCK_DATA_DATA);
  wire m_data_move  = (hi == OP_DATA_MOVE);
  wire m_in    = (nib == NIB_PORT_INPUT);
  wire m_lst0  = (hi == OP_LOAD_STATUS0);
  wire m_load_status1  = (hi == OP_LOAD_STATUS1);
  wire m_sst0  = (hi == OP_STORE_STATUS0);
  wire m_store_status1  = (hi == OP_STORE_STATUS1);
  wire m_pop_to_memory  = (hi == OP_POP_TO_MEMORY);
  wire m_push_from_memory  = (hi == OP_PUSH_FROM_MEM);
  wire m_popa  = (word == OP_POP_ACC_LOW);
  wire m_pusha = (word == OP_PUSH_ACC_LOW);
  wire m_repeat_immediate  = (hi == OP_REPEAT_IMM);
  wire m_rpt   = (hi == OP_REPEAT_MEM);
  wire m_test_bit_by_t  = (hi == OP_TEST_BIT_BY_T);
  wire m_bit   = (nib == NIB_TEST_BIT);
  wire m_block_to_data_space  = (word == OP_BLOCK_TO_DATA);
  wire m_block_to_program_space  = (word == OP_BLOCK_TO_PROG);
  wire m_clear_tx_frame_mode  = (word == OP_CLEAR_TX_FRAME);
  wire m_interrupt_disable  = (word == OP_INT_DISABLE);
  wire m_interrupt_enable  = (word == OP_INT_ENABLE);

  instr_class_t cls;

  always_comb begin
    cls = CLS_NOP;
    if (m_bz) cls = CLS_BRANCH_ACC_ZERO;            // RQ1
    else if (m_block_move_prog_to_data) cls = CLS_BLOCK_PROG_DATA;     // RQ2
    else if (m_block_move_data_to_data) cls = CLS_BLOCK_DATA_DATA;     // RQ3
    else if (m_data_move) cls = CLS_DATA_MOVE;           // RQ4
    else if (m_in) cls = CLS_PORT_INPUT;            // RQ5
    else if (m_lst0) cls = CLS_LOAD_STATUS0;        // RQ6
    else if (m_load_status1) cls = CLS_LOAD_STATUS1;        // RQ6
    else if (m_sst0) cls = CLS_STORE_STATUS0;       // RQ7
    else if (m_store_status1) cls = CLS_STORE_STATUS1;       // RQ7
    else if (m_pop_to_memory) cls = CLS_POP_TO_MEMORY;       // RQ8
    else if (m_push_from_memory) cls = CLS_PUSH_FROM_MEMORY;    // RQ9
    else if (m_popa) cls = CLS_POP_ACC_LOW;         // RQ10
    else if (m_pusha) cls = CLS_PUSH_ACC_LOW;       // RQ10
    else if (m_repeat_immediate) cls = CLS_REPEAT_IMMEDIATE;    // RQ11
    else if (m_rpt) cls = CLS_REPEAT_MEMORY;        // RQ12
    else if (m_test_bit_by_t) cls = CLS_TEST_BIT_BY_T;       // RQ13
    else if (m_bit) cls = CLS_TEST_BIT;             // RQ14
    else if (m_block_to_data_space) cls = CLS_BLOCK_TO_DATA;       // RQ15
    else if (m_block_to_program_space) cls = CLS_BLOCK_TO_PROGRAM;    // RQ16
    else if (m_clear_tx_frame_mode) cls = CLS_CLEAR_TX_FRAME;      // RQ17
    else if (m_interrupt_disable) cls = CLS_INT_DISABLE;         // RQ18
    else if (m_interrupt_enable) cls = CLS_INT_ENABLE;          // RQ18
  end

  wire any_match = m_bz | m_block_move_prog_to_data | m_block_move_data_to_data | m_data_move | m_in | m_lst0 | m_load_status1 | m_sst0
                 | m_store_status1 | m_pop_to_memory | m_push_from_memory | m_popa | m_pusha | m_repeat_immediate | m_rpt
                 | m_test_bit_by_t | m_bit | m_block_to_data_space | m_block_to_program_space | m_clear_tx_frame_mode | m_interrupt_disable | m_interrupt_enable;
  wire two_word  = m_bz | m_block_move_prog_to_data | m_block_move_data_to_data;

  // One driver for the whole struct, so no tool splits it
  assign dec = '{
    cls:      cls,
    illegal:  ~any_match,                          // RQ19
    words:    two_word ? WORDS_TWO : WORDS_ONE,    // RQ20
    indirect: word[7],
    dma:      word[6:0],
    field4:   word[11:8],                          // RQ5
    imm8:     word[7:0]                            // RQ11
  };

endmodule

// ===== dsp_pc_tracker.sv
module dsp_pc_tracker
  import dsp_decode_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        advance,
  input  wire logic [1:0]  words,
  output logic      [15:0] pc
);

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  wire [15:0] next_pc = pc + {14'h0000, words};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pc <= WORD_RESET;
    end else if (advance) begin
      pc <= next_pc; // RQ20
    end
  end

endmodule

// ===== dsp_branch_data_control_decoder.sv
// Operation
// RQ1: Upper byte F6 with bit 7 set: two-word branch if accumulator zero.
// RQ2: Upper byte FC: two-word program-to-data block move, data operand fields.
// RQ3: Data-to-data block move is a two-word instruction.
// RQ4: Upper byte 56: single-word data move with indirect flag and address.
// RQ5: Top nibble 1000: port input, port in bits 11-8, operand in low byte.
// RQ6: Upper bytes 50/51 load status register 0/1 from data memory.
// RQ7: Upper bytes 78/79 store status register 0/1 to data memory.
// RQ8: Upper byte 7A pops stack top into data memory.
// RQ9: Upper byte 54 pushes data memory word onto stack.
// RQ10: CE1D pops stack to low accumulator; CE1C pushes low accumulator.
// RQ11: Upper byte CB repeats with 8-bit immediate count.
// RQ12: Upper byte 4B repeats with count from data memory.
// RQ13: Upper byte 57 tests bit selected by temporary register.
// RQ14: Top nibble 1001 tests bit given by bits 11-8.
// RQ15: CE04 assigns the configurable block to data space.
// RQ16: CE05 assigns the configurable block to program space.
// RQ17: CE20 clears transmit framing mode, external framing.
// RQ18: CE01 disables and CE00 enables maskable interrupts.
// RQ19: Unrecognised words flag illegal and act as no-operation.
// RQ20: Two-word instructions fetch the opcode word first, then the operand word; PC advances by two.
module dsp_branch_data_control_decoder
  import dsp_decode_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] prog_word,
  input  wire logic        prog_valid,
  output logic             prog_ready,
  output logic      [15:0] prog_addr,
  output issue_t           issue,
  output logic             illegal_opcode
);

  // ----------------------------------------
  // Decode of incoming word
  // ----------------------------------------
  decode_t      word_dec;
  decode_t      held_dec;
  fetch_state_t state;
  fetch_state_t next_state;

  dsp_opcode_classifier u_classifier (
    .word (prog_word),
    .dec  (word_dec)
  );

  wire take      = prog_valid && prog_ready;
  wire take_op   = take && (state == ST_OPCODE);
  wire take_arg  = take && (state == ST_OPERAND);
  wire need_arg  = (word_dec.words == WORDS_TWO);

  // Decoder never stalls the fetch stream
  assign prog_ready = 1'b1;

  // ----------------------------------------
  // Fetch sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_OPCODE:  if (take_op && need_arg) next_state = ST_OPERAND; // RQ20
      ST_OPERAND: if (take_arg) next_state = ST_OPCODE;
      default:    next_state = ST_OPCODE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_OPCODE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      held_dec <= '0;
    end else if (take_op) begin
      held_dec <= word_dec;
    end
  end

  // ----------------------------------------
  // Issue register
  // ----------------------------------------
  // Two-word issue waits for the operand so execution sees both at once
  wire issue_now_one = take_op && !need_arg;
  wire issue_now_two = take_arg; // RQ20

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      issue <= '0;
    end else begin
      issue.valid <= issue_now_one || issue_now_two;
      if (issue_now_one) begin
        issue.dec         <= word_dec;
        issue.second_word <= WORD_RESET;
      end else if (issue_now_two) begin
        issue.dec         <= held_dec;
        issue.second_word <= prog_word; // RQ1
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      illegal_opcode <= 1'b0;
    end else begin
      illegal_opcode <= issue_now_one && word_dec.illegal; // RQ19
    end
  end

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  // Advance one per accepted word, so a two-word op moves it by two
  dsp_pc_tracker u_pc (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .advance  (take),
    .words    (WORDS_ONE),
    .pc       (prog_addr)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_branch_two_word: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ1
    take_op && prog_word[15:8] == OP_BRANCH_ACC_ZERO && prog_word[7]
      |=> state == ST_OPERAND)
    else $error("branch did not wait for target");

  a_block_prog_two: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ2
    take_op && prog_word[15:8] == OP_BLOCK_PROG_DATA |=> !issue.valid)
    else $error("program block move issued early");

  a_block_data_two: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ3
    take_op && prog_word[15:8] == OP_BLOCK_DATA_DATA ##1 take_arg
      |=> issue.valid && issue.dec.cls == CLS_BLOCK_DATA_DATA)
    else $error("data block move not issued");

  a_move_one_word: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ4
    take_op && prog_word[15:8] == OP_DATA_MOVE
      |=> issue.valid && issue.dec.cls == CLS_DATA_MOVE && issue.dec.dma == $past(prog_word[6:0]))
    else $error("data move decode wrong");

  a_port_field: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ5
    take_op && prog_word[15:12] == NIB_PORT_INPUT
      |=> issue.dec.cls == CLS_PORT_INPUT && issue.dec.field4 == $past(prog_word[11:8]))
    else $error("port input decode wrong");

  a_repeat_count: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ11
    take_op && prog_word[15:8] == OP_REPEAT_IMM
      |=> issue.dec.cls == CLS_REPEAT_IMMEDIATE && issue.dec.imm8 == $past(prog_word[7:0]))
    else $error("repeat count wrong");

  a_illegal_flag: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ19
    illegal_opcode |-> issue.valid && issue.dec.cls == CLS_NOP && issue.dec.illegal)
    else $error("illegal flag without nop issue");

  a_pc_two_step: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ20
    take_op && need_arg ##1 take_arg |=> prog_addr == $past(prog_addr, 2) + 16'h0002)
    else $error("pc did not advance by two");

  a_int_disable: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ18
    take_op && prog_word == OP_INT_DISABLE |=> issue.dec.cls == CLS_INT_DISABLE)
    else $error("interrupt disable not decoded");

endmodule

// ===== prog_mem_model.sv
// ----------------------------------------
// Program memory seen from the decoder
// ----------------------------------------
module prog_mem_model (
  input  wire logic        core_clk,
  output logic      [15:0] prog_word,
  output logic             prog_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    prog_word  = 16'h0000;
    prog_valid = 1'b0;
  end

  // One word a cycle, launched just after the edge
  task automatic put(input logic [15:0] w);
    @(posedge core_clk);
    #1;
    prog_word  = w;
    prog_valid = 1'b1;
  endtask

  // Idle bus shows the inverse, so stale data never looks valid
  task automatic idle();
    @(posedge core_clk);
    #1;
    prog_word  = ~prog_word;
    prog_valid = 1'b0;
  endtask
endmodule

// ===== dsp_branch_data_control_decoder_test.sv
module dsp_branch_data_control_decoder_test import dsp_decode_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic         core_clk;
  logic         rst_n;
  logic  [15:0] prog_word;
  logic         prog_valid;
  logic         prog_ready;
  logic  [15:0] prog_addr;
  issue_t       issue;
  logic         illegal_opcode;
  int           n_mismatch;
  int           checked;
  int           cycles;
  logic  [15:0] exp_pc;
  logic  [15:0] tw [19] = '{16'h5685, 16'h8A33, 16'h5012, 16'h51FF, 16'h7801, 16'h7980,
                           16'h7A7F, 16'h5440, 16'hCE1D, 16'hCE1C, 16'hCBFF, 16'h4B00,
                           16'h57C3, 16'h9F81, 16'hCE04, 16'hCE05, 16'hCE20, 16'hCE01,
                           16'hCE00};
  instr_class_t tc [19] = '{CLS_DATA_MOVE, CLS_PORT_INPUT, CLS_LOAD_STATUS0,
                           CLS_LOAD_STATUS1, CLS_STORE_STATUS0, CLS_STORE_STATUS1,
                           CLS_POP_TO_MEMORY, CLS_PUSH_FROM_MEMORY, CLS_POP_ACC_LOW,
                           CLS_PUSH_ACC_LOW, CLS_REPEAT_IMMEDIATE, CLS_REPEAT_MEMORY,
                           CLS_TEST_BIT_BY_T, CLS_TEST_BIT, CLS_BLOCK_TO_DATA,
                           CLS_BLOCK_TO_PROGRAM, CLS_CLEAR_TX_FRAME, CLS_INT_DISABLE,
                           CLS_INT_ENABLE};

  // ----------------------------------------
  // Clock, instances, timeout
  // ----------------------------------------
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  prog_mem_model i_mem (
    .core_clk   (core_clk),
    .prog_word  (prog_word),
    .prog_valid (prog_valid)
  );

  dsp_branch_data_control_decoder i_dut (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .prog_word      (prog_word),
    .prog_valid     (prog_valid),
    .prog_ready     (prog_ready),
    .prog_addr      (prog_addr),
    .issue          (issue),
    .illegal_opcode (illegal_opcode)
  );

  // Whole run is under fifty cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [15:0] w);
    i_mem.put(w);
    exp_pc++;
  endtask

  task automatic expect_issue(input instr_class_t cls, input logic [1:0] words,
                              input logic [15:0] second);
    check(issue.valid, 1'b1);
    check(issue.dec.cls, cls);
    check(issue.dec.words, words);
    check(issue.dec.illegal, 1'b0);
    check(issue.second_word, second);
    check(prog_addr, exp_pc);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Operand arrives after a stall; no issue meanwhile
  task automatic t_branch();
    send(16'hF680);
    i_mem.idle();
    check(issue.valid, 1'b0);
    i_mem.idle();
    check(issue.valid, 1'b0);
    send(16'h1234);
    i_mem.idle();
    expect_issue(CLS_BRANCH_ACC_ZERO, WORDS_TWO, 16'h1234);
  endtask

  // Two block moves back to back, operand fields kept
  task automatic t_block_moves();
    send(16'hFC85);
    send(16'hABCD);
    send(16'hFD03);
    // FD03 is on the bus but not yet taken, so the count runs one ahead
    exp_pc--;
    expect_issue(CLS_BLOCK_PROG_DATA, WORDS_TWO, 16'hABCD);
    exp_pc++;
    check({issue.dec.indirect, issue.dec.dma}, 8'h85);
    send(16'h5555);
    i_mem.idle();
    expect_issue(CLS_BLOCK_DATA_DATA, WORDS_TWO, 16'h5555);
    check({issue.dec.indirect, issue.dec.dma}, 8'h03);
  endtask

  // Every one-word class, one word a cycle
  task automatic t_one_word();
    for (int i = 0; i <= 19; i++) begin
      if (i < 19)
        send(tw[i]);
      else
        i_mem.idle();
      if (i > 0) begin
        check(issue.valid, 1'b1);
        check(issue.dec.cls, tc[i-1]);
        check(issue.dec.words, WORDS_ONE);
        check(illegal_opcode, 1'b0);
        check({issue.dec.indirect, issue.dec.dma}, tw[i-1][7:0]);
        check({issue.dec.field4, issue.dec.imm8}, tw[i-1][11:0]);
        check(prog_addr, exp_pc - ((i < 19) ? 16'h0001 : 16'h0000));
      end
    end
  endtask

  // Unknown words flag for one cycle only
  task automatic t_illegal();
    send(16'hF67F);
    send(16'h5500);
    check(illegal_opcode, 1'b1);
    check(issue.dec.cls, CLS_NOP);
    check(issue.dec.words, WORDS_ONE);
    send(16'hCE00);
    check(illegal_opcode, 1'b1);
    check(issue.dec.illegal, 1'b1);
    i_mem.idle();
    check(illegal_opcode, 1'b0);
    expect_issue(CLS_INT_ENABLE, WORDS_ONE, 16'h0000);
  endtask

  // Reset between opcode and operand drops the half-taken branch
  task automatic t_reset_mid();
    send(16'hF6FF);
    i_mem.idle();
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    exp_pc = 16'h0000;
    check(prog_addr, 16'h0000);
    check(issue.valid, 1'b0);
    send(16'hCB07);
    i_mem.idle();
    expect_issue(CLS_REPEAT_IMMEDIATE, WORDS_ONE, 16'h0000);
    check(issue.dec.imm8, 8'h07);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    exp_pc = 16'h0000;
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    check(prog_ready, 1'b1);
    t_branch();
    t_block_moves();
    t_one_word();
    t_illegal();
    t_reset_mid();
    results();
  end
endmodule
